// ===== dcf_defines.svh
// Purpose: Shared constants of the dual-clock FIFO
// Assumes: Included by bare name wherever the constants are needed
// Notes:   Offsets into the array are module ports, not constants
`ifndef DCF_DEFINES_SVH
`define DCF_DEFINES_SVH

// Default array depth in words, a power of two
`define DCF_DEPTH_DEF 256
// Default word width in bits
`define DCF_WIDTH_DEF 9
// Flag levels seen right after reset, all active low
`define DCF_EMPTY_N_RST 1'b0
`define DCF_FULL_N_RST 1'b1
`define DCF_HALF_N_RST 1'b1
`define DCF_DRAINED_N_RST 1'b0
`define DCF_FILLED_N_RST 1'b1

`endif

// ===== dcf_pkg.sv
// Purpose: Types shared by the dual-clock FIFO modules
// Assumes: Nothing beyond the defines header
// Notes:   All status indicators are active low
package dcf_pkg;

  // Status indicators as seen at the FIFO pins
  typedef struct packed {
    logic empty_indicator_n;           // No word left in the array for the output register
    logic full_indicator_n;            // No room for another word
    logic half_level_indicator_n;      // At least half the array used
    logic almost_drained_indicator_n;  // Level at or below the empty offset
    logic almost_filled_indicator_n;   // Level at or above full minus offset
  } dcf_flags_t;

  // One clock domain's own view of the level flags, active high
  typedef struct packed {
    logic half;
    logic drained;
    logic filled;
  } dcf_view_t;

endpackage

// ===== dcf_sync.sv
// Purpose: Two-stage synchroniser for a bus of quasi-static or gray-coded bits
// Assumes: At most one bit changes at a time, or the bus is held still
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module dcf_sync #(
  parameter int unsigned W = 1
) (
  // Destination clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Bus in the source domain and its copy in this domain
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;  // May go metastable, read by the second stage only

  // Both stages clear on reset so pointers start equal
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ===== dcf_fifo.sv
// Purpose: Dual-clock FIFO with output register and clocked status indicators
// Assumes: core_clk is the write clock and runs freely; read_clk may stop
// Notes:   Offsets are quasi-static and change only while the FIFO is idle
`timescale 1ns/1ps
`default_nettype none
`include "dcf_defines.svh"

module dcf_fifo #(
  parameter  int unsigned WIDTH = `DCF_WIDTH_DEF,
  parameter  int unsigned DEPTH = `DCF_DEPTH_DEF,
  localparam int unsigned AW    = $clog2(DEPTH)
) (
  // Write side, clocked by core_clk
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              wr_en_n,
  input  wire logic [WIDTH-1:0]  wr_data,
  // Read side, clocked by the link's read clock
  input  wire logic              read_clk,
  input  wire logic              rd_en_n,
  output logic      [WIDTH-1:0]  rd_data,
  // Programmed offsets, core_clk domain
  input  wire logic [AW-1:0]     empty_offset,
  input  wire logic [AW-1:0]     full_offset,
  // Status indicators
  output dcf_pkg::dcf_flags_t    flags
);
  import dcf_pkg::*;

  // Refuse depths the gray pointers cannot serve
  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("dcf_fifo: DEPTH must be a power of two, at least 4");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("dcf_fifo: WIDTH must be at least 1");
  end

  localparam logic [AW:0] FULL_LVL = (AW+1)'(DEPTH);      // Level when full
  localparam logic [AW:0] HALF_LVL = (AW+1)'(DEPTH / 2);  // Half level

  // Binary to gray, used for both pointers
  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // Gray to binary, used for both synchronised pointers
  function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    // Each lower bit folds in the already decoded bit above it
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // Level flags of one view, from its level and the two offsets
  function automatic dcf_view_t view_of(input logic [AW:0]   lvl,
                                        input logic [AW-1:0] e_off,
                                        input logic [AW-1:0] f_off);
    dcf_view_t v;
    v.half    = (lvl >= HALF_LVL);
    v.drained = (lvl <= {1'b0, e_off});
    v.filled  = (lvl >= (FULL_LVL - {1'b0, f_off}));
    return v;
  endfunction

  // Storage array, written on core_clk, read on read_clk
  logic [WIDTH-1:0] mem_q [DEPTH];

  // Write domain state
  logic [AW:0]  wptr_q;      // Binary write pointer
  logic [AW:0]  wptr_d;      // Write pointer after this edge
  logic [AW:0]  wgray_q;     // Gray copy that crosses to the read side
  logic [AW:0]  rgray_sync;  // Read pointer seen in the write domain
  logic [AW:0]  rsync_bin;   // Same, in binary
  logic         full_n_q;    // Full indicator
  logic         wr_go;       // A word is accepted this edge
  logic [AW:0]  lvl_w;       // Level as the write side sees it
  dcf_view_t    view_w_q;    // Write side view of the level flags

  // Read domain state
  logic         rrst_meta_q;  // Reset crossing, first stage
  logic         rrst_n_q;     // Reset in the read domain
  logic [AW:0]  rptr_q;       // Binary read pointer
  logic [AW:0]  rptr_d;       // Read pointer after this edge
  logic [AW:0]  rgray_q;      // Gray copy that crosses to the write side
  logic [AW:0]  wgray_sync;   // Write pointer seen in the read domain
  logic [AW:0]  wsync_bin;    // Same, in binary
  logic [AW-1:0] eoff_r;      // Empty offset seen in the read domain
  logic [AW-1:0] foff_r;      // Full offset seen in the read domain
  logic         empty_n_q;    // Empty indicator
  logic         rd_go;        // A word moves to the output register
  logic [AW:0]  lvl_r;        // Level as the read side sees it
  dcf_view_t    view_r_q;     // Read side view of the level flags
  logic [WIDTH-1:0] head_word; // Word waiting at the read pointer

  // ---------------- Write domain ----------------

  // Writes are refused while full, so no word is ever overwritten
  assign wr_go  = !wr_en_n && full_n_q;
  assign wptr_d = wptr_q + (AW+1)'(wr_go);
  assign rsync_bin = gray2bin(rgray_sync);
  assign lvl_w  = wptr_d - rsync_bin;

  // Read pointer crossing into the write domain
  dcf_sync #(.W(AW + 1)) u_rptr_sync (
    .clk   (core_clk),
    .rst_n (rstn),
    .d     (rgray_q),
    .q     (rgray_sync)
  );

  // Array write, storage needs no reset
  always_ff @(posedge core_clk) begin
    if (wr_go) begin
      mem_q[wptr_q[AW-1:0]] <= wr_data;
    end
  end

  // Write pointer and its gray copy
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wptr_q  <= '0;
      wgray_q <= '0;
    end else begin
      wptr_q  <= wptr_d;
      wgray_q <= bin2gray(wptr_d);
    end
  end

  // Full indicator moves only on write clock edges
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      full_n_q <= `DCF_FULL_N_RST;
    end else begin
      full_n_q <= (lvl_w != FULL_LVL);
    end
  end

  // Write side view; overestimates the level, since reads reach it late
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      view_w_q <= '{half: 1'b0, drained: 1'b1, filled: 1'b0};
    end else begin
      view_w_q <= view_of(lvl_w, empty_offset, full_offset);
    end
  end

  // ---------------- Read domain ----------------

  // Reset reaches the read side through two stages; needs read_clk edges
  always_ff @(posedge read_clk) begin
    rrst_meta_q <= rstn;
    rrst_n_q    <= rrst_meta_q;
  end

  // Write pointer crossing into the read domain
  dcf_sync #(.W(AW + 1)) u_wptr_sync (
    .clk   (read_clk),
    .rst_n (rrst_n_q),
    .d     (wgray_q),
    .q     (wgray_sync)
  );

  // Offsets cross as held levels; they must not move while in use
  dcf_sync #(.W(2 * AW)) u_off_sync (
    .clk   (read_clk),
    .rst_n (rrst_n_q),
    .d     ({empty_offset, full_offset}),
    .q     ({eoff_r, foff_r})
  );

  // A read is taken only when the array still holds a word
  assign rd_go     = !rd_en_n && empty_n_q;
  assign rptr_d    = rptr_q + (AW+1)'(rd_go);
  assign wsync_bin = gray2bin(wgray_sync);
  assign lvl_r     = wsync_bin - rptr_d;
  assign head_word = mem_q[rptr_q[AW-1:0]];

  // Read pointer and its gray copy
  always_ff @(posedge read_clk) begin
    if (!rrst_n_q) begin
      rptr_q  <= '0;
      rgray_q <= '0;
    end else begin
      rptr_q  <= rptr_d;
      rgray_q <= bin2gray(rptr_d);
    end
  end

  // Output register adds one read cycle before data shows
  always_ff @(posedge read_clk) begin
    if (!rrst_n_q) begin
      rd_data <= '0;
    end else if (rd_go) begin
      rd_data <= head_word;
    end
  end

  // Empty asserts as the last word enters the output register
  always_ff @(posedge read_clk) begin
    if (!rrst_n_q) begin
      empty_n_q <= `DCF_EMPTY_N_RST;
    end else begin
      empty_n_q <= (rptr_d != wsync_bin);
    end
  end

  // Read side view; underestimates the level, since writes reach it late
  always_ff @(posedge read_clk) begin
    if (!rrst_n_q) begin
      view_r_q <= '{half: 1'b0, drained: 1'b1, filled: 1'b0};
    end else begin
      view_r_q <= view_of(lvl_r, eoff_r, foff_r);
    end
  end

  // ---------------- Indicators ----------------

  // Fill flags take the higher view, drain flag needs both views to agree,
  // so writes lift it even while read_clk stands still
  assign flags = '{
    empty_indicator_n:          empty_n_q,
    full_indicator_n:           full_n_q,
    half_level_indicator_n:     !(view_w_q.half    || view_r_q.half),
    almost_drained_indicator_n: !(view_w_q.drained && view_r_q.drained),
    almost_filled_indicator_n:  !(view_w_q.filled  || view_r_q.filled)
  };

  // ---------------- Checks ----------------

  a_empty_last_word: assert property (
    @(posedge read_clk) disable iff (!rrst_n_q)
    (rd_go && (rptr_q + (AW+1)'(1)) == wsync_bin) |=> !flags.empty_indicator_n
  ) else $error("empty not asserted when last word entered output register");

  a_full_after_write: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $fell(full_n_q) |-> $past(wr_go)
  ) else $error("full asserted without a write edge");

  a_empty_holds_idle: assert property (
    @(posedge read_clk) disable iff (!rrst_n_q)
    (!empty_n_q && $stable(wsync_bin)) |=> !empty_n_q
  ) else $error("empty released without a new word seen");

  a_full_holds_idle: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (!full_n_q && $stable(rsync_bin)) |=> !full_n_q
  ) else $error("full released without a read seen");

  a_filled_write_clk: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (lvl_w >= (FULL_LVL - {1'b0, full_offset})) |=> !flags.almost_filled_indicator_n
  ) else $error("almost filled not raised from the write clock");

  a_read_latency: assert property (
    @(posedge read_clk) disable iff (!rrst_n_q)
    rd_go |=> (rd_data == $past(head_word)) ##1 ($past(rd_go) || $stable(rd_data))
  ) else $error("output register latency broken");

  a_half_level: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (lvl_w >= HALF_LVL) |=> !flags.half_level_indicator_n
  ) else $error("half level not asserted at half the array");

  a_drained_offset: assert property (
    @(posedge read_clk) disable iff (!rrst_n_q)
    (lvl_r > {1'b0, eoff_r}) |=> flags.almost_drained_indicator_n
  ) else $error("almost drained asserted above the empty offset");

endmodule

`default_nettype wire

// ===== dcf_rd_host.sv
// Purpose: Reading host that makes the read clock from its strobe
// Assumes: A strobe pulse starts only while run is high
// Notes:   Clock rests low between frames, never free running
`timescale 1ns/1ps
`default_nettype none

module dcf_rd_host (
  // Frame control from the bench
  input  wire logic run,
  input  wire logic sel,
  // Pins toward the FIFO
  output logic      read_clk,
  output logic      rd_en_n
);
  logic host_read_strobe;  // Active low strobe

  // 80 ns strobe cycle at an odd phase; a started pulse always ends
  initial begin
    host_read_strobe = 1'b1;
    #7;
    forever begin
      #40;
      if (run || !host_read_strobe) begin
        host_read_strobe = ~host_read_strobe;
      end
    end
  end

  assign read_clk = ~host_read_strobe;
  assign rd_en_n  = ~sel;
endmodule
`default_nettype wire

// ===== tb_top.sv
// Purpose: Self-checking bench for the dual-clock FIFO indicators
// Assumes: Read host model stops its clock between frames
// Notes:   Shallow array so the full indicator is reached quickly
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import dcf_pkg::*;
  localparam int D = 16;  // Shallow array
  // Level to reach and the indicators it should give
  typedef struct packed {
    logic [4:0] lvl;
    dcf_flags_t f;
  } dcf_row_t;
  logic       core_clk, rstn, wr_en_n, run, sel, read_clk, rd_en_n, take;
  logic [8:0] wr_data, rd_data, last_word;
  logic [8:0] exp_q[$];  // Words still owed to the reader
  logic [3:0] eoff, foff;
  dcf_flags_t flags;
  dcf_row_t   rows[8];
  int         error_cnt, tests_run, lvl;
  realtime    t_edge;

  dcf_fifo #(.WIDTH(9), .DEPTH(D)) i_dut (.core_clk(core_clk), .rstn(rstn),
    .wr_en_n(wr_en_n), .wr_data(wr_data), .read_clk(read_clk), .rd_en_n(rd_en_n),
    .rd_data(rd_data), .empty_offset(eoff), .full_offset(foff), .flags(flags));
  dcf_rd_host i_host (.run(run), .sel(sel), .read_clk(read_clk), .rd_en_n(rd_en_n));

  // 40 MHz write clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic cmp_d(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_f(input dcf_flags_t got, input dcf_flags_t exp);
    cmp_d({4'h0, got}, {4'h0, exp});
  endtask

  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Back-to-back writes; a write into a full array is refused
  task automatic put(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      wr_en_n = 1'b0;
      wr_data = 9'h1A5 ^ 9'(lvl * 37);
      if (lvl < D) exp_q.push_back(wr_data);
      lvl = (lvl < D) ? lvl + 1 : lvl;
    end
    @(negedge core_clk);
    wr_en_n = 1'b1;
  endtask

  // Reader: a taken word shows just after the read edge that takes it, the last one with empty
  always @(posedge read_clk) begin
    take = !rd_en_n && flags.empty_indicator_n;
    #1;
    if (rstn && take) begin
      last_word = exp_q.pop_front();
      cmp_d(rd_data, last_word);
      if (exp_q.size() == 0) cmp_d({8'h00, flags.empty_indicator_n}, 9'h000);
    end else if (rstn) begin
      cmp_d(rd_data, last_word);
    end
  end

  // Indicators may only move in the time step of a clock edge
  always @(posedge core_clk or posedge read_clk) t_edge = $realtime;
  always @(flags) if (rstn) cmp_d(9'($realtime == t_edge), 9'h001);

  // Watchdog, far beyond the few microseconds the run needs
  initial begin
    #50000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    rstn = 1'b0;
    wr_en_n = 1'b1;
    wr_data = 9'h000;
    run = 1'b1;
    sel = 1'b0;
    eoff = 4'h1;
    foff = 4'h2;
    lvl = 0;
    last_word = 9'h000;
    rows = '{'{5'h01, 5'h0D}, '{5'h07, 5'h0F}, '{5'h08, 5'h0B}, '{5'h0D, 5'h0B},
             '{5'h0E, 5'h0A}, '{5'h0F, 5'h0A}, '{5'h10, 5'h02}, '{5'h11, 5'h02}};
    // Long enough for four read clock edges as well
    repeat (14) @(negedge core_clk);
    cmp_f(flags, 5'h0D);
    cmp_d(rd_data, 9'h000);
    rstn = 1'b1;
    // Let the read side leave reset before its clock stops
    repeat (14) @(negedge core_clk);
    run = 1'b0;
    repeat (4) @(negedge core_clk);
    // Fill with the read clock stopped; the last row is a refused write
    foreach (rows[i]) begin
      put(rows[i].lvl - lvl);
      repeat (3) @(negedge core_clk);
      cmp_f(flags, rows[i].f);
    end
    // Restart the read clock: empty now clears
    run = 1'b1;
    repeat (24) @(negedge core_clk);
    cmp_f(flags, 5'h12);
    sel = 1'b1;
    for (int k = 0; k < 400 && exp_q.size() > 0; k++) @(negedge core_clk);
    // Keep reading an empty FIFO: the held word must not move
    repeat (24) @(negedge core_clk);
    cmp_f(flags, 5'h0D);
    sel = 1'b0;
    run = 1'b0;
    cmp_d(9'(exp_q.size()), 9'h000);
    report_and_stop();
  end
endmodule
`default_nettype wire
